// >>> rtl/psl_pkg.sv
// Shared constants and types for the pre-driver serial register link
package psl_pkg;

  // Frame layout: flag bit, seven address bits, eight data bits
  localparam int             ADDR_W      = 7;
  localparam int             DATA_W      = 8;
  localparam int             FRAME_BITS  = 16;
  localparam int             REG_DEPTH   = 128;
  localparam int             RW_POS      = 15;
  localparam int             ADDR_MSB    = 14;
  localparam int             ADDR_LSB    = 8;
  localparam logic           RW_WRITE    = 1'b0;
  localparam logic           RW_READ     = 1'b1;

  // Bit counter values seen by the device end
  localparam logic [4:0]     CNT_FIRST   = 5'h01;
  localparam logic [4:0]     CNT_ADDR    = 5'h08;
  localparam logic [4:0]     CNT_FULL    = 5'h10;
  localparam logic [4:0]     CNT_OVER    = 5'h11;

  // Reset values
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [4:0]        CNT_RESET = 5'h00;

  // Timing of the master serial clock
  localparam int REF_CLK_PERIOD_NS      = 50;
  localparam int MASTER_CLOCK_PERIOD_NS = 1000;
  localparam int MIN_MASTER_REF_CYCLES  = 4;
  localparam int MASTER_CLOCK_CYCLES_RAW =
    (MASTER_CLOCK_PERIOD_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
  localparam int MASTER_CLOCK_CYCLES =
    (MASTER_CLOCK_CYCLES_RAW < MIN_MASTER_REF_CYCLES) ? MIN_MASTER_REF_CYCLES : MASTER_CLOCK_CYCLES_RAW;
  localparam int HALF_CYCLES_INT = (MASTER_CLOCK_CYCLES + 1) / 2;
  localparam logic [4:0] HALF_LAST = 5'(HALF_CYCLES_INT - 1);
  localparam logic [5:0] EDGE_LAST = 6'(2 * FRAME_BITS - 1);
  localparam logic [5:0] GAP_LAST  = 6'(2 * MASTER_CLOCK_CYCLES - 1);

  // Master sequencer states
  typedef enum logic [1:0] {
    PSL_IDLE  = 2'b00,
    PSL_SHIFT = 2'b01,
    PSL_GAP   = 2'b10
  } psl_state_t;

endpackage : psl_pkg

// >>> rtl/psl_if.sv
// Three-wire link with chip select between master and pre-driver port
`timescale 1ns/1ps
interface psl_if;
  logic link_serial_clock;
  logic link_chip_select_n;
  logic link_serial_out;
  logic link_serial_in_o;
  logic link_serial_in_oe_n;
  wire  link_serial_in;

  // Released line shows the inverse of the output flop, so a stray sample cannot pass as data
  assign link_serial_in = link_serial_in_oe_n ? ~link_serial_in_o : link_serial_in_o;

  modport host (
    output link_serial_clock,
    output link_chip_select_n,
    output link_serial_out,
    input  link_serial_in
  );

  modport dev (
    input  link_serial_clock,
    input  link_chip_select_n,
    input  link_serial_out,
    output link_serial_in_o,
    output link_serial_in_oe_n
  );
endinterface : psl_if

// >>> rtl/psl_dev.sv
// Pre-driver end: register port of the serial link
`timescale 1ns/1ps
module psl_dev (
  // Core clock and reset
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_nrst,
  // Link mode straps, held static
  input  wire logic                        i_data_phase_select,
  input  wire logic                        i_clock_polarity_select,
  // Write notification to the pre-driver core
  output logic                             o_wr_valid,
  output logic [psl_pkg::ADDR_W-1:0]       o_wr_addr,
  output logic [psl_pkg::DATA_W-1:0]       o_wr_data,
  // Link
  psl_if.dev                               link
);

  logic [psl_pkg::DATA_W-1:0] mem_r [psl_pkg::REG_DEPTH];
  logic                       armed_r;
  logic [4:0]                 count_r;
  logic [4:0]                 count_nxt;
  logic [15:0]                sr_r;
  logic                       rw_r;
  logic                       out_r;
  logic                       oe_n_r;
  logic [7:0]                 tx_r;
  logic                       cs_m_r;
  logic                       cs_s_r;
  logic                       cs_d_r;

  wire cs_n     = link.link_chip_select_n;
  wire mosi     = link.link_serial_out;
  // Equal settings sample on rising edge, otherwise on falling edge
  wire samp_clk = link.link_serial_clock ^ (i_data_phase_select ^ i_clock_polarity_select);

  assign count_nxt = armed_r ? psl_pkg::CNT_FIRST :
                     (count_r == psl_pkg::CNT_OVER) ? count_r : count_r + 5'h01;

  // Chip select high arms the counter for the next frame
  always_ff @(posedge samp_clk or posedge cs_n) begin
    if (cs_n) begin
      armed_r <= 1'b1;
    end else begin
      armed_r <= 1'b0;
    end
  end

  always_ff @(posedge samp_clk) begin
    count_r <= count_nxt;
    sr_r    <= {sr_r[14:0], mosi};
    rw_r    <= armed_r ? mosi : rw_r;
  end

  // Read data comes from the core array; it only changes between frames
  wire [7:0] rd_byte   = mem_r[sr_r[psl_pkg::ADDR_W-1:0]];
  // Counter and flag hold the last frame until the first sample; phase-one modes shift first
  wire       in_frame  = ~armed_r;
  wire       drive_low = in_frame && (count_r == psl_pkg::CNT_FIRST) && (rw_r == psl_pkg::RW_WRITE);
  wire       load_rd   = in_frame && (count_r == psl_pkg::CNT_ADDR) && (rw_r == psl_pkg::RW_READ);
  wire       shift_rd  = in_frame && (count_r > psl_pkg::CNT_ADDR) && (count_r < psl_pkg::CNT_FULL) &&
                         (rw_r == psl_pkg::RW_READ);

  always_ff @(negedge samp_clk or posedge cs_n) begin
    if (cs_n) begin
      oe_n_r <= 1'b1;
      out_r  <= 1'b0;
      tx_r   <= 8'h00;
    end else if (drive_low) begin
      oe_n_r <= 1'b0;
      out_r  <= 1'b0;
    end else if (load_rd) begin
      oe_n_r <= 1'b0;
      out_r  <= rd_byte[7];
      tx_r   <= {rd_byte[6:0], 1'b0};
    end else if (shift_rd) begin
      out_r  <= tx_r[7];
      tx_r   <= {tx_r[6:0], 1'b0};
    end
  end

  assign link.link_serial_in_o    = out_r;
  assign link.link_serial_in_oe_n = oe_n_r;

  // Frame end seen in the core domain; frame words are frozen while select is high
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      cs_m_r <= 1'b1;
      cs_s_r <= 1'b1;
      cs_d_r <= 1'b1;
    end else begin
      cs_m_r <= cs_n;
      cs_s_r <= cs_m_r;
      cs_d_r <= cs_s_r;
    end
  end

  wire frame_end = cs_s_r & ~cs_d_r;
  // Only a complete sixteen-bit write frame is acted on
  wire wr_hit    = frame_end && (count_r == psl_pkg::CNT_FULL) && (rw_r == psl_pkg::RW_WRITE);

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      for (int i = 0; i < psl_pkg::REG_DEPTH; i++) begin
        mem_r[i] <= psl_pkg::REG_RESET;
      end
      o_wr_valid <= 1'b0;
      o_wr_addr  <= 7'h00;
      o_wr_data  <= psl_pkg::REG_RESET;
    end else begin
      o_wr_valid <= wr_hit;
      if (wr_hit) begin
        mem_r[sr_r[psl_pkg::ADDR_MSB:psl_pkg::ADDR_LSB]] <= sr_r[7:0];
        o_wr_addr <= sr_r[psl_pkg::ADDR_MSB:psl_pkg::ADDR_LSB];
        o_wr_data <= sr_r[7:0];
      end
    end
  end

endmodule : psl_dev

// >>> rtl/psl_host.sv
// Controller end: master of the pre-driver serial register link
//
// Overview of operation
// - Master channel serves only the pre-driver link.
// - Slave-select input stays disabled, never used.
// - Link supports register write and register read.
// - Write frame: low flag, address MSB first.
// - Write data follows address, MSB first.
// - Pre-driver floats input line, then drives low.
// - Read frame: high flag, address; rest ignored.
// - Malformed frames are ignored by the pre-driver.
// - Equal settings: sample rising, change after falling.
// - Differing settings invert the clock edge roles.
// - Serial clock period at least 1000 ns.
`timescale 1ns/1ps
module psl_host (
  // Clock and reset
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_nrst,
  // Link mode
  input  wire logic                        i_data_phase_select,
  input  wire logic                        i_clock_polarity_select,
  // Command
  input  wire logic                        i_req,
  input  wire logic                        i_rw,
  input  wire logic [psl_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [psl_pkg::DATA_W-1:0]  i_wdata,
  // Answer
  output logic                             o_ready,
  output logic                             o_done,
  output logic [psl_pkg::DATA_W-1:0]       o_rdata,
  // Link; this channel is wired to nothing but the pre-driver
  psl_if.host                              link
);

  psl_pkg::psl_state_t state_r;
  psl_pkg::psl_state_t state_nxt;
  logic [4:0]          div_r;
  logic [4:0]          div_nxt;
  logic [5:0]          edge_r;
  logic [5:0]          edge_nxt;
  logic [5:0]          gap_r;
  logic [5:0]          gap_nxt;
  logic [15:0]         sr_r;
  logic [15:0]         sr_nxt;
  logic [7:0]          rx_r;
  logic [7:0]          rx_nxt;
  logic                sck_r;
  logic                sck_nxt;
  logic                cs_n_r;
  logic                cs_n_nxt;
  logic                sampled_r;
  logic                sampled_nxt;
  logic                dps_r;
  logic                dps_nxt;
  logic                cps_r;
  logic                cps_nxt;
  logic                ready_r;
  logic                ready_nxt;
  logic                done_r;
  logic                done_nxt;
  logic [7:0]          rdata_r;
  logic [7:0]          rdata_nxt;
  logic                miso_m_r;
  logic                miso_s_r;

  // Clock divider tick every half period of the serial clock
  wire half_tick = (div_r == psl_pkg::HALF_LAST);
  wire inv       = dps_r ^ cps_r;
  wire eff       = sck_r ^ inv;
  // Sample edge is the rising edge of the effective clock
  wire e_rise    = half_tick & ~eff;
  wire e_fall    = half_tick & eff;
  wire last_edge = (edge_r == psl_pkg::EDGE_LAST);
  wire take      = i_req & ready_r;
  wire gap_half  = (gap_r == 6'(psl_pkg::HALF_LAST));
  wire gap_end   = (gap_r == psl_pkg::GAP_LAST);
  // Flag, address, then data; flag low writes, high reads
  wire [15:0] frame = {i_rw, i_addr, i_wdata};

  always_comb begin
    state_nxt   = state_r;
    div_nxt     = div_r;
    edge_nxt    = edge_r;
    gap_nxt     = gap_r;
    sr_nxt      = sr_r;
    rx_nxt      = rx_r;
    sck_nxt     = sck_r;
    cs_n_nxt    = cs_n_r;
    sampled_nxt = sampled_r;
    dps_nxt     = dps_r;
    cps_nxt     = cps_r;
    ready_nxt   = ready_r;
    done_nxt    = 1'b0;
    rdata_nxt   = rdata_r;
    unique case (state_r)
      psl_pkg::PSL_IDLE: begin
        ready_nxt = 1'b1;
        dps_nxt   = i_data_phase_select;
        cps_nxt   = i_clock_polarity_select;
        // Idle level of the clock follows the polarity setting
        sck_nxt   = i_clock_polarity_select;
        if (take) begin
          sr_nxt      = frame;
          cs_n_nxt    = 1'b0;
          div_nxt     = 5'h00;
          edge_nxt    = 6'h00;
          sampled_nxt = 1'b0;
          ready_nxt   = 1'b0;
          state_nxt   = psl_pkg::PSL_SHIFT;
        end
      end
      psl_pkg::PSL_SHIFT: begin
        div_nxt = half_tick ? 5'h00 : div_r + 5'h01;
        if (half_tick) begin
          sck_nxt  = ~sck_r;
          edge_nxt = edge_r + 6'h01;
        end
        if (e_rise) begin
          // Only the last eight samples survive in the receive byte
          rx_nxt      = {rx_r[6:0], miso_s_r};
          sampled_nxt = 1'b1;
        end
        // Phase-one mode opens with a shift edge that must not advance
        if (e_fall && sampled_r) begin
          sr_nxt = {sr_r[14:0], 1'b0};
        end
        if (half_tick && last_edge) begin
          gap_nxt   = 6'h00;
          state_nxt = psl_pkg::PSL_GAP;
        end
      end
      psl_pkg::PSL_GAP: begin
        gap_nxt = gap_r + 6'h01;
        if (gap_half) begin
          cs_n_nxt = 1'b1;
        end
        // Gap also lets the pre-driver commit the frame before the next
        if (gap_end) begin
          done_nxt  = 1'b1;
          rdata_nxt = rx_r;
          ready_nxt = 1'b1;
          state_nxt = psl_pkg::PSL_IDLE;
        end
      end
      default: begin
        cs_n_nxt  = 1'b1;
        state_nxt = psl_pkg::PSL_IDLE;
      end
    endcase
  end

  // Returned line comes from the other end's clock domain
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      miso_m_r <= 1'b0;
      miso_s_r <= 1'b0;
    end else begin
      miso_m_r <= link.link_serial_in;
      miso_s_r <= miso_m_r;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      state_r   <= psl_pkg::PSL_IDLE;
      div_r     <= 5'h00;
      edge_r    <= 6'h00;
      gap_r     <= 6'h00;
      sr_r      <= 16'h0000;
      rx_r      <= 8'h00;
      sck_r     <= 1'b0;
      cs_n_r    <= 1'b1;
      sampled_r <= 1'b0;
      dps_r     <= 1'b0;
      cps_r     <= 1'b0;
      ready_r   <= 1'b0;
      done_r    <= 1'b0;
      rdata_r   <= 8'h00;
    end else begin
      state_r   <= state_nxt;
      div_r     <= div_nxt;
      edge_r    <= edge_nxt;
      gap_r     <= gap_nxt;
      sr_r      <= sr_nxt;
      rx_r      <= rx_nxt;
      sck_r     <= sck_nxt;
      cs_n_r    <= cs_n_nxt;
      sampled_r <= sampled_nxt;
      dps_r     <= dps_nxt;
      cps_r     <= cps_nxt;
      ready_r   <= ready_nxt;
      done_r    <= done_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // No select input exists on this channel; only the select output is used
  assign link.link_serial_clock  = sck_r;
  assign link.link_chip_select_n = cs_n_r;
  assign link.link_serial_out    = sr_r[psl_pkg::RW_POS];
  assign o_ready                 = ready_r;
  assign o_done                  = done_r;
  assign o_rdata                 = rdata_r;

endmodule : psl_host

// >>> testbench/psl_props.sv
// Checker for the link between host and pre-driver
`timescale 1ns/1ps
module psl_props (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Link mode
  input wire logic i_data_phase_select,
  input wire logic i_clock_polarity_select,
  // Link
  input wire logic link_serial_clock,
  input wire logic link_chip_select_n,
  input wire logic link_serial_out,
  input wire logic link_serial_in_o,
  input wire logic link_serial_in_oe_n
);
  logic       sck_d_r;
  logic       cs_d_r;
  logic       rw_r;
  logic       rw_nxt;
  logic [5:0] edge_cnt_r;
  logic [5:0] edge_cnt_nxt;
  wire        sck_moved = link_serial_clock != sck_d_r;
  wire        eff_clk   = link_serial_clock ^ i_data_phase_select ^ i_clock_polarity_select;

  // Count is one sample late, so read bounds are one below the edge numbers
  assign rw_nxt       = (cs_d_r && !link_chip_select_n) ? link_serial_out : rw_r;
  assign edge_cnt_nxt = link_chip_select_n ? 6'h00 : (sck_moved ? edge_cnt_r + 6'h01 : edge_cnt_r);

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      sck_d_r    <= 1'b0;
      cs_d_r     <= 1'b1;
      rw_r       <= 1'b0;
      edge_cnt_r <= 6'h00;
    end else begin
      sck_d_r    <= link_serial_clock;
      cs_d_r     <= link_chip_select_n;
      rw_r       <= rw_nxt;
      edge_cnt_r <= edge_cnt_nxt;
    end
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  a_idle_clk_level: assert property (
    $rose(link_chip_select_n) |-> link_serial_clock == i_clock_polarity_select) else $error("sck not idle");
  a_sixteen_bits: assert property (
    $rose(link_chip_select_n) |-> edge_cnt_r == 6'h20) else $error("frame edge count");
  a_half_period: assert property (
    !link_chip_select_n && sck_moved |=> $stable(link_serial_clock) [*8]) else $error("sck too fast");
  a_select_gap: assert property (
    $rose(link_chip_select_n) |-> link_chip_select_n [*8]) else $error("select gap short");
  a_float_idle: assert property (
    link_chip_select_n |-> link_serial_in_oe_n) else $error("miso driven idle");
  a_first_bit_float: assert property (
    $fell(link_chip_select_n) |-> link_serial_in_oe_n [*8]) else $error("miso driven early");
  a_float_first_edge: assert property (
    !link_chip_select_n && edge_cnt_r == 6'h00 |-> link_serial_in_oe_n) else $error("miso driven before first edge");
  a_write_low: assert property (
    !link_chip_select_n && !link_serial_in_oe_n && rw_r == psl_pkg::RW_WRITE |-> link_serial_in_o == 1'b0)
    else $error("write miso not low");
  a_read_addr_float: assert property (
    !link_chip_select_n && rw_r == psl_pkg::RW_READ && edge_cnt_r < 6'h0F |-> link_serial_in_oe_n)
    else $error("read miso early");
  a_mosi_shift_edge: assert property (
    !link_chip_select_n && !$fell(link_chip_select_n) && $changed(link_serial_out) |-> sck_moved && !eff_clk)
    else $error("mosi changed off shift edge");
endmodule : psl_props

// >>> testbench/predriver_serial_reg_link_tb.sv
// Testbench: host and pre-driver joined, second pre-driver fed by hand
`timescale 1ns/1ps
module predriver_serial_reg_link_tb;
  logic       i_ref_clk;
  logic       i_nrst;
  logic       i_data_phase_select;
  logic       i_clock_polarity_select;
  logic       i_req;
  logic       i_rw;
  logic [6:0] i_addr;
  logic [7:0] i_wdata;
  logic       o_ready;
  logic       o_done;
  logic [7:0] o_rdata;
  logic       o_wr_valid;
  logic [6:0] o_wr_addr;
  logic [7:0] o_wr_data;
  logic       b_wr_valid;
  logic [6:0] b_wr_addr;
  logic [7:0] b_wr_data;
  int         err_count;
  int         compares;
  int         cycles;
  int         wr_cnt;
  int         b_wr_cnt;
  logic [6:0] addr_tab [4] = '{7'h00, 7'h7F, 7'h2A, 7'h55};
  logic [7:0] data_tab [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h01};

  psl_if i_psl_if ();
  psl_if i_psl_if_b ();

  psl_host i_psl_host (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_data_phase_select(i_data_phase_select),
    .i_clock_polarity_select(i_clock_polarity_select), .i_req(i_req), .i_rw(i_rw), .i_addr(i_addr),
    .i_wdata(i_wdata), .o_ready(o_ready), .o_done(o_done), .o_rdata(o_rdata), .link(i_psl_if));
  psl_dev i_psl_dev (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_data_phase_select(i_data_phase_select),
    .i_clock_polarity_select(i_clock_polarity_select), .o_wr_valid(o_wr_valid), .o_wr_addr(o_wr_addr),
    .o_wr_data(o_wr_data), .link(i_psl_if));
  // Hand-driven end, mode fixed at zero
  psl_dev i_psl_dev_b (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_data_phase_select(1'b0),
    .i_clock_polarity_select(1'b0), .o_wr_valid(b_wr_valid), .o_wr_addr(b_wr_addr),
    .o_wr_data(b_wr_data), .link(i_psl_if_b));
  psl_props i_psl_props (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_data_phase_select(i_data_phase_select),
    .i_clock_polarity_select(i_clock_polarity_select), .link_serial_clock(i_psl_if.link_serial_clock),
    .link_chip_select_n(i_psl_if.link_chip_select_n), .link_serial_out(i_psl_if.link_serial_out),
    .link_serial_in_o(i_psl_if.link_serial_in_o), .link_serial_in_oe_n(i_psl_if.link_serial_in_oe_n));

  initial i_ref_clk = 1'b0;
  always #25 i_ref_clk = ~i_ref_clk;

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // Whole run needs about 6300 cycles
  always @(posedge i_ref_clk) begin
    cycles++;
    if (o_wr_valid === 1'b1) wr_cnt++;
    if (b_wr_valid === 1'b1) b_wr_cnt++;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic host_op(input logic rw, input logic [6:0] a, input logic [7:0] d);
    int n;
    n = 0;
    do @(negedge i_ref_clk); while (o_ready !== 1'b1);
    @(posedge i_ref_clk);
    i_req   <= 1'b1;
    i_rw    <= rw;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_req <= 1'b0;
    while (o_done !== 1'b1 && n < 500) begin
      @(negedge i_ref_clk);
      n++;
    end
    check("done latency", {7'h00, n >= 361 && n <= 363}, 8'h01);
    check("ready at done", {7'h00, o_ready}, 8'h01);
  endtask : host_op

  // Mode zero frame; tail -1 drops the last bit, +1 adds one
  task automatic raw_frame(input logic [15:0] w, input int tail);
    for (int k = 0; k < 16 + tail; k++) begin
      @(posedge i_ref_clk);
      i_psl_if_b.link_chip_select_n <= 1'b0;
      i_psl_if_b.link_serial_out    <= (k < 16) ? w[15-k] : ~w[0];
      repeat (10) @(posedge i_ref_clk);
      i_psl_if_b.link_serial_clock <= 1'b1;
      repeat (10) @(posedge i_ref_clk);
      i_psl_if_b.link_serial_clock <= 1'b0;
    end
    repeat (10) @(posedge i_ref_clk);
    i_psl_if_b.link_chip_select_n <= 1'b1;
    i_psl_if_b.link_serial_out    <= ~i_psl_if_b.link_serial_out;
    repeat (40) @(posedge i_ref_clk);
  endtask : raw_frame

  initial begin
    {i_nrst, i_req, i_rw, i_addr, i_wdata} = '0;
    {i_data_phase_select, i_clock_polarity_select} = 2'b00;
    {i_psl_if_b.link_chip_select_n, i_psl_if_b.link_serial_clock, i_psl_if_b.link_serial_out} = 3'b100;
    {err_count, compares, cycles, wr_cnt, b_wr_cnt} = '0;
    repeat (5) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    host_op(psl_pkg::RW_READ, 7'h00, 8'h00);
    check("reset rdata", o_rdata, psl_pkg::REG_RESET);
    host_op(psl_pkg::RW_READ, 7'h7F, 8'h00);
    check("reset rdata", o_rdata, psl_pkg::REG_RESET);
    check("read writes", 8'(wr_cnt), 8'h00);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      @(posedge i_ref_clk);
      {i_data_phase_select, i_clock_polarity_select} <= 2'(m);
      host_op(psl_pkg::RW_WRITE, addr_tab[m], data_tab[m]);
      check("wr addr", {1'b0, o_wr_addr}, {1'b0, addr_tab[m]});
      check("wr data", o_wr_data, data_tab[m]);
      check("wr count", 8'(wr_cnt), 8'(m + 1));
      check("write rdata", o_rdata, 8'h00);
      host_op(psl_pkg::RW_READ, addr_tab[m], 8'h00);
      check("rdata", o_rdata, data_tab[m]);
    end
    $display("test modes done");
    @(posedge i_ref_clk);
    {i_data_phase_select, i_clock_polarity_select} <= 2'b00;
    for (int m = 0; m < 4; m++) begin
      host_op(psl_pkg::RW_READ, addr_tab[m], 8'hFF);
      check("kept rdata", o_rdata, data_tab[m]);
    end
    check("read writes", 8'(wr_cnt), 8'h04);
    $display("test readback done");
    raw_frame({psl_pkg::RW_WRITE, 7'h33, 8'hC3}, -1);
    raw_frame({psl_pkg::RW_WRITE, 7'h33, 8'hC3}, 1);
    check("bad frames", 8'(b_wr_cnt), 8'h00);
    raw_frame({psl_pkg::RW_WRITE, 7'h33, 8'hC3}, 0);
    check("good frame", 8'(b_wr_cnt), 8'h01);
    check("b addr", {1'b0, b_wr_addr}, 8'h33);
    check("b data", b_wr_data, 8'hC3);
    $display("test frame format done");
    report_and_stop();
  end
endmodule : predriver_serial_reg_link_tb
